/* File: dds_top.sv */
// Digital control of a dual voltage output DAC with serial command link.
`timescale 1ns/1ps
`default_nettype none
module dds_top #(
  parameter int DAC_RES = 12
) (
  // System clock and reset
  input  wire logic                    CLOCK,
  input  wire logic                    RST_B,
  // Serial link, clocked by the host's serial clock
  input  wire logic                    SCLK,
  input  wire logic                    SYNC_N,
  input  wire logic                    SDIN,
  // Asynchronous control pins
  input  wire logic                    LOAD_STROBE_N,
  input  wire logic                    CLEAR_N,
  input  wire logic                    HW_POWERDOWN_N,
  // Channel A outputs
  output var  logic [DAC_RES-1:0]      DAC_CODE_A,
  output var  logic                    GAIN_A,
  output var  dds_pkg::dds_out_t       OUT_CTL_A,
  // Channel B outputs
  output var  logic [DAC_RES-1:0]      DAC_CODE_B,
  output var  logic                    GAIN_B,
  output var  dds_pkg::dds_out_t       OUT_CTL_B
);

  // ****************************************************************
  // Link domain: shift register on falling serial clock
  // ****************************************************************
  logic [15:0] shift_ff;
  logic [4:0]  bit_cnt_ff;
  logic        word_tgl_ff;
  logic [15:0] word_ff;
  logic        frame_rst_n;

  // Frame select high clears the counter so each frame restarts.
  assign frame_rst_n = RST_B & ~SYNC_N;

  always_ff @(negedge SCLK or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_ff   <= 16'h0000;
      bit_cnt_ff <= 5'h00;
    end else if (bit_cnt_ff != dds_pkg::LAST_BIT) begin
      shift_ff   <= {shift_ff[14:0], SDIN};
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
  end

  // Completed word is captured and signalled by a toggle.
  always_ff @(negedge SCLK or negedge RST_B) begin
    if (!RST_B) begin
      word_tgl_ff <= 1'b0;
      word_ff     <= 16'h0000;
    end else if (!SYNC_N &&
                 bit_cnt_ff == dds_pkg::LAST_BIT - 5'h01) begin
      word_tgl_ff <= ~word_tgl_ff;
      word_ff     <= {shift_ff[14:0], SDIN};
    end
  end

  // ****************************************************************
  // Crossing into the system clock domain
  // ****************************************************************
  logic [2:0] tgl_sync_ff;
  logic [1:0] load_sync_ff;
  logic [1:0] clr_sync_ff;
  logic [1:0] pd_sync_ff;
  logic       word_evt;
  logic       word_chan;
  logic       hw_pd_on;

  // The word toggle passes two flip-flops; the third finds its edge.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tgl_sync_ff <= 3'h0;
    end else begin
      tgl_sync_ff <= {tgl_sync_ff[1:0], word_tgl_ff};
    end
  end

  // The load chain resets to the idle level so no false load follows.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      load_sync_ff <= 2'h3;
    end else begin
      load_sync_ff <= {load_sync_ff[0], LOAD_STROBE_N};
    end
  end

  // The power-down chain also resets to its idle level.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pd_sync_ff <= 2'h3;
    end else begin
      pd_sync_ff <= {pd_sync_ff[0], HW_POWERDOWN_N};
    end
  end

  // Clear acts at once but is released through two flip-flops.
  always_ff @(posedge CLOCK or negedge CLEAR_N) begin
    if (!CLEAR_N) begin
      clr_sync_ff <= 2'h0;
    end else begin
      clr_sync_ff <= {clr_sync_ff[0], 1'b1};
    end
  end

  // The word register is stable for many cycles after the toggle.
  assign word_evt  = tgl_sync_ff[2] ^ tgl_sync_ff[1];
  assign word_chan = word_ff[dds_pkg::BIT_CHAN];
  assign hw_pd_on  = ~pd_sync_ff[1];

  // ****************************************************************
  // Input and DAC registers
  // ****************************************************************
  dds_pkg::dds_chan_t in_a_ff;
  dds_pkg::dds_chan_t in_b_ff;
  dds_pkg::dds_chan_t dac_a_ff;
  dds_pkg::dds_chan_t dac_b_ff;
  logic               dirty_a_ff;
  logic               dirty_b_ff;
  logic               reg_rst_n;
  logic               load_on;
  logic               wr_a;
  logic               wr_b;
  logic               copy_a;
  logic               copy_b;
  dds_pkg::dds_chan_t nxt_word;

  // A completed word hits the channel that its select bit names.
  function automatic logic chan_hit(input logic evt,
                                    input logic sel,
                                    input logic idx);
    return evt && (sel == idx);
  endfunction

  assign reg_rst_n = RST_B & CLEAR_N & clr_sync_ff[1];
  assign load_on   = ~load_sync_ff[1];
  assign wr_a      = chan_hit(word_evt, word_chan, 1'b0);
  assign wr_b      = chan_hit(word_evt, word_chan, 1'b1);
  assign copy_a    = load_on & dirty_a_ff & ~wr_a;
  assign copy_b    = load_on & dirty_b_ff & ~wr_b;

  always_comb begin
    nxt_word.gain    = word_ff[dds_pkg::BIT_GAIN];
    nxt_word.pd_mode = word_ff[dds_pkg::BIT_PD_MSB:dds_pkg::BIT_PD_LSB];
    nxt_word.code    = word_ff[dds_pkg::DATA_MSB:0] &
                       ({dds_pkg::DAC_BITS{1'b1}} <<
                        (dds_pkg::DAC_BITS - DAC_RES));
  end

  always_ff @(posedge CLOCK or negedge reg_rst_n) begin
    if (!reg_rst_n) begin
      in_a_ff <= dds_pkg::CHAN_RST;
    end else if (wr_a) begin
      in_a_ff <= nxt_word;
    end
  end

  always_ff @(posedge CLOCK or negedge reg_rst_n) begin
    if (!reg_rst_n) begin
      in_b_ff <= dds_pkg::CHAN_RST;
    end else if (wr_b) begin
      in_b_ff <= nxt_word;
    end
  end

  always_ff @(posedge CLOCK or negedge reg_rst_n) begin
    if (!reg_rst_n) begin
      dirty_a_ff <= 1'b0;
    end else if (wr_a) begin
      dirty_a_ff <= 1'b1;
    end else if (copy_a) begin
      dirty_a_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge reg_rst_n) begin
    if (!reg_rst_n) begin
      dirty_b_ff <= 1'b0;
    end else if (wr_b) begin
      dirty_b_ff <= 1'b1;
    end else if (copy_b) begin
      dirty_b_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge reg_rst_n) begin
    if (!reg_rst_n) begin
      dac_a_ff <= dds_pkg::CHAN_RST;
    end else if (copy_a) begin
      dac_a_ff <= in_a_ff;
    end
  end

  always_ff @(posedge CLOCK or negedge reg_rst_n) begin
    if (!reg_rst_n) begin
      dac_b_ff <= dds_pkg::CHAN_RST;
    end else if (copy_b) begin
      dac_b_ff <= in_b_ff;
    end
  end

  // ****************************************************************
  // Output stage control
  // ****************************************************************
  function automatic dds_pkg::dds_out_t out_ctl(input logic [1:0] mode,
                                                 input logic       hw_pd);
    dds_pkg::dds_out_t o;
    o = '{sw_1k: 1'b0, sw_100k: 1'b0, sw_hiz: 1'b0, amp_on: 1'b0};
    if (hw_pd) begin
      o.sw_hiz = 1'b1;
    end else begin
      case (mode)
        dds_pkg::PD_NORMAL: o.amp_on  = 1'b1;
        dds_pkg::PD_1K:     o.sw_1k   = 1'b1;
        dds_pkg::PD_100K:   o.sw_100k = 1'b1;
        default:            o.sw_hiz  = 1'b1;
      endcase
    end
    return o;
  endfunction

  // Output stage state while reset holds: amplifier on, no switch closed.
  localparam dds_pkg::dds_out_t CTL_IDLE = '{sw_1k: 1'b0, sw_100k: 1'b0,
                                             sw_hiz: 1'b0, amp_on: 1'b1};

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      DAC_CODE_A <= '0;
      GAIN_A     <= 1'b0;
      OUT_CTL_A  <= CTL_IDLE;
    end else begin
      DAC_CODE_A <= dac_a_ff.code[dds_pkg::DATA_MSB -: DAC_RES];
      GAIN_A     <= dac_a_ff.gain;
      OUT_CTL_A  <= out_ctl(dac_a_ff.pd_mode, hw_pd_on);
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      DAC_CODE_B <= '0;
      GAIN_B     <= 1'b0;
      OUT_CTL_B  <= CTL_IDLE;
    end else begin
      DAC_CODE_B <= dac_b_ff.code[dds_pkg::DATA_MSB -: DAC_RES];
      GAIN_B     <= dac_b_ff.gain;
      OUT_CTL_B  <= out_ctl(dac_b_ff.pd_mode, hw_pd_on);
    end
  end

endmodule
`default_nettype wire

/* File: dds_pkg.sv */
// Package with constants and types for the dual DAC serial control block.
package dds_pkg;
  // ****************************************************************
  // Command word layout
  // ****************************************************************
  localparam int WORD_BITS   = 16;
  localparam int CNT_W       = 5;
  localparam int BIT_CHAN    = 15;
  localparam int BIT_GAIN    = 14;
  localparam int BIT_PD_MSB  = 13;
  localparam int BIT_PD_LSB  = 12;
  localparam int DATA_MSB    = 11;
  localparam int DAC_BITS    = 12;
  localparam logic [4:0] LAST_BIT = 5'h10;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K     = 2'h1;
  localparam logic [1:0] PD_100K   = 2'h2;
  localparam logic [1:0] PD_HIZ    = 2'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic        gain;
    logic [1:0]  pd_mode;
    logic [11:0] code;
  } dds_chan_t;

  typedef struct packed {
    logic sw_1k;
    logic sw_100k;
    logic sw_hiz;
    logic amp_on;
  } dds_out_t;

  localparam dds_chan_t CHAN_RST = '{gain: 1'b0, pd_mode: 2'h0,
                                     code: 12'h000};
endpackage

/* File: dds_assertions.sv */
// Port assertions for the dual DAC serial control block.
`timescale 1ns/1ps
`default_nettype none
module dds_assertions #(
  parameter int DAC_RES = 12
) (
  input wire logic               CLOCK,
  input wire logic               RST_B,
  input wire logic               SCLK,
  input wire logic               SYNC_N,
  input wire logic               SDIN,
  input wire logic               LOAD_STROBE_N,
  input wire logic               CLEAR_N,
  input wire logic               HW_POWERDOWN_N,
  input wire logic [DAC_RES-1:0] DAC_CODE_A,
  input wire logic               GAIN_A,
  input wire dds_pkg::dds_out_t  OUT_CTL_A,
  input wire logic [DAC_RES-1:0] DAC_CODE_B,
  input wire logic               GAIN_B,
  input wire dds_pkg::dds_out_t  OUT_CTL_B
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  a_reset_zero_out: assert property (
    $rose(RST_B) |-> !DAC_CODE_A && !DAC_CODE_B && !GAIN_A && !GAIN_B)
    else $error("nonzero after reset");
  a_clear_zeroes: assert property (
    !CLEAR_N [*2] |-> !DAC_CODE_A && !DAC_CODE_B && !GAIN_A && !GAIN_B)
    else $error("clear ignored");
  a_clear_normal: assert property (
    (!CLEAR_N && HW_POWERDOWN_N) [*4] |-> OUT_CTL_A.amp_on && OUT_CTL_B.amp_on)
    else $error("mode not normal after clear");
  a_pin_forces_hiz: assert property (
    !HW_POWERDOWN_N [*4] |-> OUT_CTL_A.sw_hiz && OUT_CTL_B.sw_hiz)
    else $error("pin power-down ignored");
  a_ctl_onehot: assert property (
    $onehot(OUT_CTL_A) && $onehot(OUT_CTL_B))
    else $error("switch controls not one-hot");
  a_load_high_holds: assert property (
    (LOAD_STROBE_N && CLEAR_N) [*7] |-> $stable(DAC_CODE_A) && $stable(GAIN_A)
      && $stable(DAC_CODE_B) && $stable(GAIN_B))
    else $error("code moved while load high");
  a_pd_keeps_code: assert property (
    (!HW_POWERDOWN_N && CLEAR_N && LOAD_STROBE_N) [*7] |-> $stable(DAC_CODE_B))
    else $error("power-down changed code");
  a_idle_link_quiet: assert property (
    (SYNC_N && CLEAR_N && $stable(LOAD_STROBE_N)) [*8] |->
      $stable(DAC_CODE_A) && $stable(DAC_CODE_B))
    else $error("code moved with link idle");
endmodule
`default_nettype wire

/* File: dds_host.sv */
// Serial host model that frames and shifts command words.
`timescale 1ns/1ps
`default_nettype none
module dds_host (
  output var logic sclk,
  output var logic sync_n,
  output var logic sdin
);
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdin = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n);
    sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #62.5 sclk = 1'b1;
      sdin = (i < 16) ? w[15-i] : !sdin;
      #62.5 sclk = 1'b0;
    end
    #62.5 sync_n = 1'b1;
    sdin = !sdin;
    #250;
  endtask
endmodule
`default_nettype wire

/* File: test_dual_dac_serial_control.sv */
// Self-checking bench for the dual DAC serial control block.
`timescale 1ns/1ps
`default_nettype none
module test_dual_dac_serial_control;
  logic              clock = 1'b0;
  logic              rst_b = 1'b0;
  logic              load_strobe_n = 1'b0;
  logic              clear_n = 1'b1;
  logic              hw_powerdown_n = 1'b1;
  logic              sclk, sync_n, sdin, gain_a, gain_b;
  logic [11:0]       code_a, code_b;
  logic [7:0]        code_a8, code_b8;
  dds_pkg::dds_out_t ctl_a, ctl_b;
  logic [15:0]       e [2];
  logic [15:0]       w;
  int                bad_count = 0;
  int                checks = 0;
  always #5 clock = ~clock;
  dds_host u_host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));
  dds_top u_dut (.CLOCK(clock), .RST_B(rst_b), .SCLK(sclk), .SYNC_N(sync_n),
    .SDIN(sdin), .LOAD_STROBE_N(load_strobe_n), .CLEAR_N(clear_n),
    .HW_POWERDOWN_N(hw_powerdown_n), .DAC_CODE_A(code_a), .GAIN_A(gain_a),
    .OUT_CTL_A(ctl_a), .DAC_CODE_B(code_b), .GAIN_B(gain_b),
    .OUT_CTL_B(ctl_b));
  dds_top #(.DAC_RES(8)) u_dut8 (.CLOCK(clock), .RST_B(rst_b), .SCLK(sclk),
    .SYNC_N(sync_n), .SDIN(sdin), .LOAD_STROBE_N(load_strobe_n),
    .CLEAR_N(clear_n), .HW_POWERDOWN_N(hw_powerdown_n), .DAC_CODE_A(code_a8),
    .GAIN_A(), .OUT_CTL_A(), .DAC_CODE_B(code_b8), .GAIN_B(), .OUT_CTL_B());
  function automatic dds_pkg::dds_out_t ctl(input logic [1:0] m);
    return '{m == 2'h1, m == 2'h2, m == 2'h3, m == 2'h0};
  endfunction
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic look(input int c);
    logic [15:0] x;
    x = e[c];
    chk(c ? code_b : code_a, x[11:0]);
    chk(12'(c ? code_b8 : code_a8), 12'(x[11:4]));
    chk(12'(c ? gain_b : gain_a), 12'(x[14]));
    chk(12'(c ? ctl_b : ctl_a), 12'(ctl(hw_powerdown_n ? x[13:12] : 2'h3)));
  endtask
  task automatic both;
    look(0);
    look(1);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic complete_run;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h84db3d99));
    e[0] = '0;
    e[1] = '0;
    tick(10);
    rst_b = 1'b1;
    tick(2);
    both;
    for (int i = 0; i < 8; i++) begin
      w = 16'($urandom);
      w[13:12] = 2'(i);
      u_host.send(w, 16);
      e[w[15]] = w;
      tick(8);
      look(int'(w[15]));
    end
    load_strobe_n = 1'b1;
    u_host.send(16'h4FFF, 16);
    tick(8);
    look(0);
    e[0] = 16'h4FFF;
    load_strobe_n = 1'b0;
    tick(8);
    both;
    u_host.send(16'h0123, 15);
    u_host.send(16'h8FF0, 20);
    e[1] = 16'h8FF0;
    tick(8);
    both;
    hw_powerdown_n = 1'b0;
    tick(5);
    both;
    hw_powerdown_n = 1'b1;
    tick(5);
    both;
    clear_n = 1'b0;
    tick(3);
    clear_n = 1'b1;
    e[0] = '0;
    e[1] = '0;
    tick(3);
    both;
    complete_run;
  end
endmodule
bind dds_top dds_assertions #(.DAC_RES(DAC_RES)) u_chk (.CLOCK(CLOCK),
  .RST_B(RST_B), .SCLK(SCLK), .SYNC_N(SYNC_N), .SDIN(SDIN),
  .LOAD_STROBE_N(LOAD_STROBE_N), .CLEAR_N(CLEAR_N),
  .HW_POWERDOWN_N(HW_POWERDOWN_N), .DAC_CODE_A(DAC_CODE_A), .GAIN_A(GAIN_A),
  .OUT_CTL_A(OUT_CTL_A), .DAC_CODE_B(DAC_CODE_B), .GAIN_B(GAIN_B),
  .OUT_CTL_B(OUT_CTL_B));
`default_nettype wire
